// *** csc_sysctl.sv ***
// csc_sysctl.sv: system-control and block-move execution unit
`timescale 1ns/1ps
module csc_sysctl (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic issue_valid,
   input wire csc_pkg::csc_op_t issue_op,
   input wire csc_pkg::csc_am_t issue_am,
   input wire logic issue_adv,
   input wire logic [7:0] issue_imm,
   input wire logic [23:0] issue_disp,
   input wire logic [1:0] issue_vec,
   input wire logic [31:0] issue_pc,
   input wire logic [31:0] issue_sp,
   input wire logic [31:0] issue_ptr,
   input wire logic [7:0] issue_reg8,
   input wire logic [15:0] issue_count,
   input wire logic [15:0] issue_src,
   input wire logic [15:0] issue_dst,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack,
   output logic busy_q,
   output logic done_q,
   output logic [7:0] ccr_q,
   output logic [31:0] pc_q,
   output logic [31:0] sp_q,
   output logic [31:0] ptr_q,
   output logic ptr_wr_q,
   output logic [7:0] reg8_q,
   output logic reg8_wr_q,
   output logic [15:0] count_q,
   output logic [15:0] src_q,
   output logic [15:0] dst_q,
   output logic [csc_pkg::TW-1:0] states_q,
   output logic mem_req_q,
   output logic mem_we_q,
   output logic mem_word_q,
   output logic [31:0] mem_addr_q,
   output logic [15:0] mem_wdata_q
);
   typedef enum logic [1:0] {st_idle, st_setup, st_wait, st_pad} csc_fsm_t;

   csc_fsm_t st_q, st_d;
   csc_pkg::csc_op_t op_q, op_d;
   csc_pkg::csc_am_t am_q, am_d;
   logic adv_q, adv_d, busy_d, done_d, ptr_wr_d, reg8_wr_d;
   logic [23:0] disp_q, disp_d;
   logic [31:0] vec_q, vec_d, pc_d, sp_d, ptr_d, ea, addr_d;
   logic [7:0] ccr_d, reg8_d, tmp_q, tmp_d, opnd, alu_out;
   logic [15:0] count_d, src_d, dst_d, n0_q, n0_d, wdata_d;
   logic [2:0] step_q, step_d, pcw;
   logic req_d, we_d, word_d;
   logic acc, a_we, a_word, cnt_zero, start, reached;
   logic [31:0] a_addr;
   logic [15:0] a_wd, n_in;
   csc_pkg::csc_op_t alu_op;

   assign pcw = adv_q ? 3'h2 : 3'h1; // return address words
   assign cnt_zero = (op_q == csc_pkg::op_bmovb) ? (count_q[7:0] == 8'h00)
                                                 : (count_q == 16'h0000);
   assign n_in = (issue_op == csc_pkg::op_bmovb) ? {8'h00, issue_count[7:0]} : issue_count;
   assign alu_op = (st_q == st_idle) ? issue_op : op_q;

   // flags operand: memory word high byte, byte register or immediate
   always_comb begin
      if (st_q == st_wait) begin
         opnd = mem_rdata[15:8];
      end else if (issue_op == csc_pkg::op_ldc && issue_am == csc_pkg::am_reg) begin
         opnd = issue_reg8;
      end else begin
         opnd = issue_imm;
      end
   end

   csc_flag_alu u_alu (
      .op(alu_op),
      .condition_code_reg(ccr_q),
      .opnd(opnd),
      .ccr_new(alu_out)
   );

   csc_state_timer #(
      .W(csc_pkg::TW)
   ) u_timer (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .start(start),
      .target(csc_pkg::min_states(issue_op, issue_am, issue_adv, n_in)),
      .elapsed_q(states_q),
      .reached(reached)
   );

   // effective address of the flags load or store operand
   always_comb begin
      case (am_q)
         csc_pkg::am_d16: ea = ptr_q + {{16{disp_q[15]}}, disp_q[15:0]};
         csc_pkg::am_d24: ea = ptr_q + {{8{disp_q[23]}}, disp_q};
         // store steps down before writing, load reads first and steps up later
         csc_pkg::am_step: ea = (op_q == csc_pkg::op_stc) ? ptr_q - csc_pkg::PTR_STEP
                                                          : ptr_q;
         csc_pkg::am_a16: ea = {{16{disp_q[15]}}, disp_q[15:0]};
         csc_pkg::am_a24: ea = {8'h00, disp_q};
         default: ea = ptr_q;
      endcase
   end

   // memory access wanted at the current step
   always_comb begin
      acc = 1'b0;
      a_we = 1'b0;
      a_word = 1'b1;
      a_addr = sp_q - csc_pkg::PTR_STEP;
      a_wd = {ccr_q, ccr_q};
      case (op_q)
         csc_pkg::op_trap: begin
            if (step_q < pcw) begin
               acc = 1'b1;
               a_we = 1'b1;
               a_wd = (adv_q && step_q == 3'h1) ? pc_q[31:16] : pc_q[15:0];
            end else if (step_q == pcw) begin
               acc = 1'b1;
               a_we = 1'b1;
            end else if (step_q <= {pcw[1:0], 1'b0}) begin
               acc = 1'b1;
               a_addr = vec_q + {28'h000_0000, step_q - pcw - 3'h1, 1'b0};
            end
         end
         csc_pkg::op_rte: begin
            if (step_q <= pcw) begin
               acc = 1'b1;
               a_addr = sp_q;
            end
         end
         csc_pkg::op_ldc, csc_pkg::op_stc: begin
            if (am_q >= csc_pkg::am_ind && step_q == 3'h0) begin
               acc = 1'b1;
               a_we = (op_q == csc_pkg::op_stc);
               a_addr = ea;
            end
         end
         csc_pkg::op_bmovb, csc_pkg::op_bmovw: begin
            if (!cnt_zero) begin
               acc = 1'b1;
               a_word = 1'b0;
               a_we = step_q[0];
               a_addr = step_q[0] ? {16'h0000, dst_q} : {16'h0000, src_q};
               a_wd = {8'h00, tmp_q};
            end
         end
         default: acc = 1'b0;
      endcase
   end

   // sequencer next state
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      am_d = am_q;
      adv_d = adv_q;
      disp_d = disp_q;
      vec_d = vec_q;
      busy_d = busy_q;
      done_d = 1'b0;
      ptr_wr_d = 1'b0;
      reg8_wr_d = 1'b0;
      ccr_d = ccr_q;
      pc_d = pc_q;
      sp_d = sp_q;
      ptr_d = ptr_q;
      reg8_d = reg8_q;
      count_d = count_q;
      src_d = src_q;
      dst_d = dst_q;
      n0_d = n0_q;
      tmp_d = tmp_q;
      step_d = step_q;
      req_d = mem_req_q;
      we_d = mem_we_q;
      word_d = mem_word_q;
      addr_d = mem_addr_q;
      wdata_d = mem_wdata_q;
      start = 1'b0;
      case (st_q)
         st_idle: begin
            if (issue_valid) begin
               start = 1'b1;
               busy_d = 1'b1;
               st_d = st_setup;
               step_d = 3'h0;
               op_d = issue_op;
               am_d = issue_am;
               adv_d = issue_adv;
               disp_d = issue_disp;
               // vector entries are one word in normal mode, two in advanced mode
               vec_d = csc_pkg::VEC_BASE + {27'h000_0000, issue_adv ? {1'b0, issue_vec, 2'b00}
                                                                    : {2'b00, issue_vec, 1'b0}};
               pc_d = issue_pc;
               sp_d = issue_sp;
               ptr_d = issue_ptr;
               reg8_d = issue_reg8;
               count_d = issue_count;
               src_d = issue_src;
               dst_d = issue_dst;
               n0_d = n_in;
               case (issue_op)
                  csc_pkg::op_ldc: begin
                     if (issue_am < csc_pkg::am_ind) begin
                        ccr_d = alu_out;
                     end
                  end
                  csc_pkg::op_stc: begin
                     if (issue_am < csc_pkg::am_ind) begin
                        reg8_d = ccr_q;
                     end
                  end
                  csc_pkg::op_and_flags_imm, csc_pkg::op_orc, csc_pkg::op_xor_flags_imm: begin
                     ccr_d = alu_out;
                  end
                  csc_pkg::op_nop: pc_d = issue_pc + csc_pkg::PTR_STEP;
                  default: ccr_d = ccr_q;
               endcase
            end
         end
         st_setup: begin
            if (acc) begin
               req_d = 1'b1;
               we_d = a_we;
               word_d = a_word;
               addr_d = a_addr;
               wdata_d = a_wd;
               st_d = st_wait;
            end else begin
               st_d = st_pad;
            end
         end
         st_wait: begin
            // wait states simply stretch the instruction
            if (mem_ack) begin
               req_d = 1'b0;
               we_d = 1'b0;
               step_d = step_q + 3'h1;
               st_d = st_setup;
               case (op_q)
                  csc_pkg::op_trap: begin
                     if (step_q <= pcw) begin
                        sp_d = sp_q - csc_pkg::PTR_STEP;
                     end
                     if (step_q == pcw) begin
                        ccr_d[csc_pkg::CCR_IMASK] = 1'b1;
                     end
                     if (step_q > pcw) begin
                        pc_d = adv_q ? {pc_q[15:0], mem_rdata} : {16'h0000, mem_rdata};
                     end
                  end
                  csc_pkg::op_rte: begin
                     sp_d = sp_q + csc_pkg::PTR_STEP;
                     if (step_q == 3'h0) begin
                        ccr_d = mem_rdata[15:8];
                     end else begin
                        pc_d = adv_q ? {pc_q[15:0], mem_rdata} : {16'h0000, mem_rdata};
                     end
                  end
                  csc_pkg::op_ldc: begin
                     ccr_d = alu_out;
                     if (am_q == csc_pkg::am_step) begin
                        ptr_d = ptr_q + csc_pkg::PTR_STEP;
                     end
                  end
                  csc_pkg::op_stc: begin
                     if (am_q == csc_pkg::am_step) begin
                        ptr_d = ptr_q - csc_pkg::PTR_STEP;
                     end
                  end
                  csc_pkg::op_bmovb, csc_pkg::op_bmovw: begin
                     if (!step_q[0]) begin
                        tmp_d = mem_rdata[7:0];
                     end else begin
                        src_d = src_q + 16'h0001;
                        dst_d = dst_q + 16'h0001;
                        step_d = 3'h0;
                        if (op_q == csc_pkg::op_bmovb) begin
                           count_d[7:0] = count_q[7:0] - 8'h01;
                        end else begin
                           count_d = count_q - 16'h0001;
                        end
                     end
                  end
                  default: step_d = step_q + 3'h1;
               endcase
            end
         end
         st_pad: begin
            // never finish before the least state count
            if (reached) begin
               done_d = 1'b1;
               busy_d = 1'b0;
               st_d = st_idle;
               ptr_wr_d = (op_q == csc_pkg::op_ldc || op_q == csc_pkg::op_stc)
                          && am_q == csc_pkg::am_step;
               reg8_wr_d = (op_q == csc_pkg::op_stc) && am_q == csc_pkg::am_reg;
            end
         end
         default: st_d = st_idle;
      endcase
   end

   // register everything
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= st_idle;
         op_q <= csc_pkg::op_nop;
         am_q <= csc_pkg::am_imm;
         adv_q <= 1'b0;
         disp_q <= 24'h00_0000;
         vec_q <= 32'h0000_0000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         ptr_wr_q <= 1'b0;
         reg8_wr_q <= 1'b0;
         ccr_q <= csc_pkg::CCR_RST;
         pc_q <= 32'h0000_0000;
         sp_q <= 32'h0000_0000;
         ptr_q <= 32'h0000_0000;
         reg8_q <= 8'h00;
         count_q <= 16'h0000;
         src_q <= 16'h0000;
         dst_q <= 16'h0000;
         n0_q <= 16'h0000;
         tmp_q <= 8'h00;
         step_q <= 3'h0;
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_word_q <= 1'b0;
         mem_addr_q <= 32'h0000_0000;
         mem_wdata_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         am_q <= am_d;
         adv_q <= adv_d;
         disp_q <= disp_d;
         vec_q <= vec_d;
         busy_q <= busy_d;
         done_q <= done_d;
         ptr_wr_q <= ptr_wr_d;
         reg8_wr_q <= reg8_wr_d;
         ccr_q <= ccr_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
         ptr_q <= ptr_d;
         reg8_q <= reg8_d;
         count_q <= count_d;
         src_q <= src_d;
         dst_q <= dst_d;
         n0_q <= n0_d;
         tmp_q <= tmp_d;
         step_q <= step_d;
         mem_req_q <= req_d;
         mem_we_q <= we_d;
         mem_word_q <= word_d;
         mem_addr_q <= addr_d;
         mem_wdata_q <= wdata_d;
      end
   end

   // checks on sequencing and results
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   property p_trap_mask;
      done_q && op_q == csc_pkg::op_trap |-> ccr_q[csc_pkg::CCR_IMASK]
         && states_q == {12'h000, adv_q ? csc_pkg::ST_TRAP_A : csc_pkg::ST_TRAP_N};
   endproperty
   a_trap_mask: assert property (p_trap_mask) else $error("trap mask or time wrong");

   property p_trap_push;
      st_q == st_wait && op_q == csc_pkg::op_trap && step_q == pcw
         |-> mem_we_q && mem_wdata_q[15:8] == ccr_q && mem_addr_q == sp_q - 32'h2;
   endproperty
   a_trap_push: assert property (p_trap_push) else $error("flags push out of place");

   property p_rte_ccr;
      st_q == st_wait && mem_ack && op_q == csc_pkg::op_rte && step_q == 3'h0
         |=> ccr_q == $past(mem_rdata[15:8]) ##1 mem_req_q && mem_addr_q == sp_q;
   endproperty
   a_rte_ccr: assert property (p_rte_ccr) else $error("return flags pop wrong");

   property p_ldc_imm;
      st_q == st_idle && issue_valid && issue_op == csc_pkg::op_ldc
         && issue_am == csc_pkg::am_imm |=> ccr_q == $past(issue_imm) ##1 !done_q ##1 done_q;
   endproperty
   a_ldc_imm: assert property (p_ldc_imm) else $error("immediate flags load wrong");

   property p_ldc_inc;
      st_q == st_wait && mem_ack && op_q == csc_pkg::op_ldc && am_q == csc_pkg::am_step
         |-> mem_addr_q == ptr_q ##1 ptr_q == $past(ptr_q) + 32'h2;
   endproperty
   a_ldc_inc: assert property (p_ldc_inc) else $error("post-increment wrong");

   property p_stc_keep;
      st_q != st_idle && op_q == csc_pkg::op_stc |=> ccr_q == $past(ccr_q);
   endproperty
   a_stc_keep: assert property (p_stc_keep) else $error("flags changed by store");

   property p_stc_dec;
      st_q == st_wait && mem_ack && op_q == csc_pkg::op_stc && am_q == csc_pkg::am_step
         |-> mem_addr_q == ptr_q - 32'h2 ##1 ptr_q == mem_addr_q;
   endproperty
   a_stc_dec: assert property (p_stc_dec) else $error("pre-decrement wrong");

   property p_bmov_zero;
      st_q == st_setup && csc_pkg::is_bmov(op_q) && cnt_zero |=> !mem_req_q;
   endproperty
   a_bmov_zero: assert property (p_bmov_zero) else $error("move past zero count");

   property p_bmovw_end;
      done_q && op_q == csc_pkg::op_bmovw |-> count_q == 16'h0000;
   endproperty
   a_bmovw_end: assert property (p_bmovw_end) else $error("word count not zero at end");

   property p_bmov_step;
      st_q == st_wait && mem_ack && csc_pkg::is_bmov(op_q) && step_q[0]
         |-> mem_we_q && mem_wdata_q[7:0] == tmp_q
         ##1 src_q == $past(src_q) + 16'h1 && dst_q == $past(dst_q) + 16'h1;
   endproperty
   a_bmov_step: assert property (p_bmov_step) else $error("move iteration wrong");

   property p_bmov_time;
      done_q && csc_pkg::is_bmov(op_q) |-> states_q == {2'b00, n0_q, 2'b00} + 20'h0_0008;
   endproperty
   a_bmov_time: assert property (p_bmov_time) else $error("move state count wrong");

   property p_and_flags_imm;
      st_q == st_idle && issue_valid && issue_op == csc_pkg::op_and_flags_imm
         |=> ccr_q == ($past(ccr_q) & $past(issue_imm)) ##2 done_q;
   endproperty
   a_and_flags_imm: assert property (p_and_flags_imm) else $error("flags and-immediate wrong");

   c_trap: cover property (done_q && op_q == csc_pkg::op_trap && adv_q);
   c_rte: cover property (done_q && op_q == csc_pkg::op_rte);
   c_bmov: cover property (done_q && op_q == csc_pkg::op_bmovw && n0_q > 16'h0002);
endmodule

// *** csc_pkg.sv ***
// csc_pkg.sv: shared types, constants and the state-count table
package csc_pkg;
   // instructions handled by the system-control unit
   typedef enum logic [3:0] {
      op_nop, op_trap, op_rte, op_ldc, op_stc, op_and_flags_imm, op_orc, op_xor_flags_imm, op_bmovb, op_bmovw
   } csc_op_t;
   // operand forms of the flags load and store
   typedef enum logic [2:0] {
      am_imm, am_reg, am_ind, am_d16, am_d24, am_step, am_a16, am_a24
   } csc_am_t;
   localparam int TW = 20; // state counter width
   localparam logic [7:0] CCR_RST = 8'h80; // interrupt mask set
   localparam int CCR_IMASK = 7;
   localparam logic [31:0] VEC_BASE = 32'h0000_0010; // trap vector table base
   localparam logic [31:0] PTR_STEP = 32'h0000_0002; // word pointer step
   // least state counts with on-chip code and operands
   localparam logic [7:0] ST_TRAP_N = 8'h0E;
   localparam logic [7:0] ST_TRAP_A = 8'h10;
   localparam logic [7:0] ST_RTE = 8'h0A;
   localparam logic [7:0] ST_SHORT = 8'h02;
   localparam logic [7:0] ST_IND = 8'h06;
   localparam logic [7:0] ST_MEM8 = 8'h08; // d16, pointer step, aa16
   localparam logic [7:0] ST_D24 = 8'h0C;
   localparam logic [7:0] ST_A24 = 8'h0A;
   localparam logic [7:0] ST_BMOV = 8'h08;

   // block move of either count width
   function automatic logic is_bmov(csc_op_t op);
      is_bmov = (op == op_bmovb) || (op == op_bmovw);
   endfunction

   // least number of states for one instruction
   function automatic logic [TW-1:0] min_states(csc_op_t op, csc_am_t am, logic adv,
                                               logic [15:0] n);
      logic [7:0] b;
      b = ST_SHORT;
      case (op)
         op_trap: b = adv ? ST_TRAP_A : ST_TRAP_N;
         op_rte: b = ST_RTE;
         op_ldc, op_stc: begin
            case (am)
               am_ind: b = ST_IND;
               am_d16, am_step, am_a16: b = ST_MEM8;
               am_d24: b = ST_D24;
               am_a24: b = ST_A24;
               default: b = ST_SHORT;
            endcase
         end
         op_bmovb, op_bmovw: b = ST_BMOV;
         default: b = ST_SHORT;
      endcase
      min_states = {12'h000, b};
      if (is_bmov(op)) begin
         min_states = min_states + {2'b00, n, 2'b00};
      end
   endfunction
endpackage

// *** csc_flag_alu.sv ***
// csc_flag_alu.sv: next flags value for load and logic-immediate forms
`timescale 1ns/1ps
module csc_flag_alu (
   input wire csc_pkg::csc_op_t op,
   input wire logic [7:0] condition_code_reg,
   input wire logic [7:0] opnd,
   output logic [7:0] ccr_new
);
   // bitwise combine or plain load, else keep
   always_comb begin
      case (op)
         csc_pkg::op_ldc: ccr_new = opnd;
         csc_pkg::op_and_flags_imm: ccr_new = condition_code_reg & opnd;
         csc_pkg::op_orc: ccr_new = condition_code_reg | opnd;
         csc_pkg::op_xor_flags_imm: ccr_new = condition_code_reg ^ opnd;
         default: ccr_new = condition_code_reg;
      endcase
   end
endmodule

// *** csc_state_timer.sv ***
// csc_state_timer.sv: counts states of one instruction up to its least count
`timescale 1ns/1ps
module csc_state_timer #(
   parameter int W = 20
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [W-1:0] target,
   output logic [W-1:0] elapsed_q,
   output logic reached
);
   logic [W-1:0] target_q;
   logic [W-1:0] target_d;
   logic [W-1:0] elapsed_d;

   assign reached = elapsed_q >= target_q;

   // reload on start, then count until the target is met
   always_comb begin
      target_d = start ? target : target_q;
      elapsed_d = elapsed_q;
      if (start) begin
         elapsed_d = {{(W-1){1'b0}}, 1'b1};
      end else if (!reached) begin
         elapsed_d = elapsed_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         target_q <= '0;
         elapsed_q <= '0;
      end else begin
         target_q <= target_d;
         elapsed_q <= elapsed_d;
      end
   end
endmodule

// *** csc_mem_model.sv ***
// csc_mem_model.sv: byte memory answering the unit's data port
`timescale 1ns/1ps
module csc_mem_model (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [3:0] wait_n,
   input wire logic mem_req_q,
   input wire logic mem_we_q,
   input wire logic mem_word_q,
   input wire logic [31:0] mem_addr_q,
   input wire logic [15:0] mem_wdata_q,
   output logic [15:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] bytes [256];
   logic [3:0] cnt_q;
   logic [15:0] junk_q;
   logic [7:0] a;
   logic [7:0] a1;
   // ack after wait_n extra cycles; data is junk outside acks
   assign a = mem_addr_q[7:0];
   assign a1 = a + 8'h01;
   assign mem_ack = mem_req_q && (cnt_q == wait_n);
   assign mem_rdata = !mem_ack ? junk_q : mem_word_q ? {bytes[a], bytes[a1]} : {~bytes[a], bytes[a]};
   // wait counter, toggling junk, big-endian writes
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 4'h0;
         junk_q <= 16'h5a5a;
      end else begin
         junk_q <= ~junk_q;
         cnt_q <= (mem_ack || !mem_req_q) ? 4'h0 : cnt_q + 4'h1;
         if (mem_ack && mem_we_q && mem_word_q) begin
            bytes[a] <= mem_wdata_q[15:8];
            bytes[a1] <= mem_wdata_q[7:0];
         end else if (mem_ack && mem_we_q) begin
            bytes[a] <= mem_wdata_q[7:0];
         end
      end
   end
endmodule

// *** testbench.sv ***
// testbench.sv: self-checking bench for the system-control unit
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 0;
   logic arst_n = 0;
   logic issue_valid = 0;
   csc_pkg::csc_op_t issue_op = csc_pkg::op_nop;
   csc_pkg::csc_am_t issue_am = csc_pkg::am_imm;
   logic issue_adv = 0;
   logic [7:0] issue_imm = 0, issue_reg8 = 0, v, old;
   logic [23:0] issue_disp = 0;
   logic [1:0] issue_vec = 0;
   logic [31:0] issue_pc = 0, issue_sp = 0, issue_ptr = 0, mask;
   logic [15:0] issue_count = 0, issue_src = 0, issue_dst = 0, mem_rdata, count_q, src_q, dst_q;
   logic [15:0] mem_wdata_q;
   logic [3:0] wait_n = 0;
   logic mem_ack, busy_q, done_q, ptr_wr_q, reg8_wr_q, mem_req_q, mem_we_q, mem_word_q;
   logic [7:0] ccr_q, reg8_q, b;
   logic [31:0] pc_q, sp_q, ptr_q, mem_addr_q;
   logic [csc_pkg::TW-1:0] states_q;
   int fails = 0, check_count = 0, cyc, k, i, n;
   logic [7:0] q [$];
   csc_pkg::csc_am_t ams [5] = '{csc_pkg::am_ind, csc_pkg::am_d16, csc_pkg::am_d24,
                                csc_pkg::am_a16, csc_pkg::am_a24};
   int sts [5] = '{6, 8, 12, 8, 10};
   logic [7:0] adr [5] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h80};
   csc_sysctl dut (.ref_clk, .arst_n, .issue_valid, .issue_op, .issue_am, .issue_adv, .issue_imm,
      .issue_disp, .issue_vec, .issue_pc, .issue_sp, .issue_ptr, .issue_reg8, .issue_count,
      .issue_src, .issue_dst, .mem_rdata, .mem_ack, .busy_q, .done_q, .ccr_q, .pc_q, .sp_q,
      .ptr_q, .ptr_wr_q, .reg8_q, .reg8_wr_q, .count_q, .src_q, .dst_q, .states_q, .mem_req_q,
      .mem_we_q, .mem_word_q, .mem_addr_q, .mem_wdata_q);
   csc_mem_model mem (.ref_clk, .arst_n, .wait_n, .mem_req_q, .mem_we_q, .mem_word_q,
      .mem_addr_q, .mem_wdata_q, .mem_rdata, .mem_ack);
   always #4 ref_clk = ~ref_clk;
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      check_count++;
      if (e !== g) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // issue one instruction, wait for done, check the state count
   task automatic run(csc_pkg::csc_op_t op, csc_pkg::csc_am_t am, int t);
      issue_op = op;
      issue_am = am;
      issue_valid = 1;
      @(posedge ref_clk);
      #1 issue_valid = 0;
      for (cyc = 1; cyc < 3000 && done_q !== 1'b1; cyc++) begin
         @(posedge ref_clk);
         #1;
      end
      if (done_q !== 1'b1) fails++;
      if (done_q !== 1'b1) tally_and_finish();
      if (t > 0) chk("states", t, states_q);
   endtask
   initial begin
      void'($urandom(92400));
      repeat (2) @(posedge ref_clk);
      #1 arst_n = 1;
      // logic immediates on flags, then no-op
      v = 8'h80;
      for (k = 0; k < 4; k++) begin
         issue_imm = 8'($urandom);
         issue_pc = $urandom;
         run(k < 3 ? csc_pkg::csc_op_t'(k + 5) : csc_pkg::op_nop, csc_pkg::am_imm, 2);
         v = k == 0 ? v & issue_imm : k == 1 ? v | issue_imm : k == 2 ? v ^ issue_imm : v;
         chk("flags_logic", v, ccr_q);
      end
      chk("nop_pc", issue_pc + 2, pc_q);
      // flags load from immediate and register, store to register
      issue_reg8 = 8'($urandom);
      run(csc_pkg::op_ldc, csc_pkg::am_imm, 2);
      chk("ldc_imm", issue_imm, ccr_q);
      run(csc_pkg::op_ldc, csc_pkg::am_reg, 2);
      chk("ldc_reg", issue_reg8, ccr_q);
      run(csc_pkg::op_stc, csc_pkg::am_reg, 2);
      chk("stc_reg", {1'b1, issue_reg8}, {reg8_wr_q, reg8_q});
      // memory forms: load, then store of a new value
      issue_ptr = 32'h0000_0040;
      for (k = 0; k < 5; k++) begin
         issue_disp = {16'h0000, adr[k] - ((k == 3 || k == 4) ? 8'h00 : 8'h40)};
         v = 8'($urandom);
         mem.bytes[adr[k]] = v;
         run(csc_pkg::op_ldc, ams[k], sts[k]);
         chk("ldc_mem", v, ccr_q);
         issue_imm = ~v;
         run(csc_pkg::op_ldc, csc_pkg::am_imm, 2);
         run(csc_pkg::op_stc, ams[k], sts[k]);
         chk("stc_mem", {~v, ~v, ~v}, {mem.bytes[adr[k]], mem.bytes[adr[k] + 8'h01], ccr_q});
      end
      // post-increment load and pre-decrement store
      issue_ptr = 32'h0000_0090;
      v = 8'($urandom);
      mem.bytes[8'h90] = v;
      run(csc_pkg::op_ldc, csc_pkg::am_step, 8);
      chk("ldc_step", {1'b1, v, 32'h0000_0092}, {ptr_wr_q, ccr_q, ptr_q});
      issue_ptr = 32'h0000_00a0;
      run(csc_pkg::op_stc, csc_pkg::am_step, 8);
      chk("stc_step", {v, 32'h0000_009e}, {mem.bytes[8'h9e], ptr_q});
      // trap in normal then advanced mode
      issue_sp = 32'h0000_00f0;
      for (k = 0; k < 2; k++) begin
         issue_adv = k[0];
         issue_vec = 2'($urandom);
         issue_pc = $urandom;
         old = ccr_q;
         b = 8'h10 + 8'(issue_vec) * (k[0] ? 8'h04 : 8'h02);
         for (i = 0; i < 4; i++) mem.bytes[b + 8'(i)] = 8'($urandom);
         run(csc_pkg::op_trap, csc_pkg::am_imm, 14 + 2 * k);
         mask = k[0] ? 32'hffff_ffff : 32'h0000_ffff;
         chk("trap_pc", mask & {mem.bytes[b], mem.bytes[b + 8'h01], mem.bytes[b + 8'h02],
            mem.bytes[b + 8'h03]} >> (k[0] ? 0 : 16), mask & pc_q);
         chk("trap_sp", 32'h0000_00ec - 32'(2 * k), sp_q);
         chk("trap_push", {issue_pc[15:0], old, 1'b1},
            {mem.bytes[8'hee], mem.bytes[8'hef], mem.bytes[8'hec - 8'(2 * k)], ccr_q[7]});
      end
      // exception return in normal mode
      issue_adv = 0;
      issue_sp = 32'h0000_00c0;
      for (i = 0; i < 4; i++) mem.bytes[8'hc0 + 8'(i)] = 8'($urandom);
      run(csc_pkg::op_rte, csc_pkg::am_imm, 10);
      chk("rte", {mem.bytes[8'hc0], mem.bytes[8'hc2], mem.bytes[8'hc3], 32'h0000_00c4},
         {ccr_q, pc_q[15:0], sp_q});
      // block moves, byte form keeps the upper count byte
      for (k = 0; k < 4; k++) begin
         n = k == 0 ? 0 : $urandom % 6 + 1;
         issue_count = k[0] ? 16'(n) : {8'ha5, 8'(n)};
         issue_src = 16'h0020 + 16'(k * 8);
         issue_dst = 16'h00b0 + 16'(k * 8);
         for (i = 0; i < n; i++) q.push_back(8'($urandom));
         for (i = 0; i < n; i++) mem.bytes[issue_src[7:0] + 8'(i)] = q[i];
         run(k[0] ? csc_pkg::op_bmovw : csc_pkg::op_bmovb, csc_pkg::am_imm, 8 + 4 * n);
         for (i = 0; i < n; i++) chk("bmov_data", q.pop_front(), mem.bytes[issue_dst[7:0] + 8'(i)]);
         chk("bmov_regs", {issue_src + 16'(n), issue_dst + 16'(n)}, {src_q, dst_q});
         chk("bmov_count", k[0] ? 16'h0000 : 16'ha500, count_q);
      end
      // slow memory stretches the load
      wait_n = 4'h3;
      issue_ptr = 32'h0000_0040;
      v = 8'($urandom);
      mem.bytes[8'h40] = v;
      run(csc_pkg::op_ldc, csc_pkg::am_ind, 0);
      chk("slow_load", {v, 1'b1}, {ccr_q, cyc > 7});
      tally_and_finish();
   end
endmodule
